/* src/status_pkg.sv */
package status_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_STATE_FLAGS = 8'h00;
  localparam logic [7:0] OFF_NET_STATE = 8'h04;
  localparam logic [7:0] OFF_ERR_CODE = 8'h08;
  localparam logic [7:0] OFF_ERR_COUNT = 8'h0C;
  localparam logic [7:0] OFF_ERR_LOG = 8'h10;
  localparam logic [7:0] OFF_HOST_SUP = 8'h14;
  localparam logic [7:0] OFF_VERSION = 8'h18;
  localparam logic [7:0] OFF_TIMEOUT = 8'h1C;
  localparam logic [7:0] OFF_ACTIVE = 8'h20;
  localparam logic [7:0] OFF_CONFIGURED = 8'h24;
  localparam logic [7:0] OFF_FAULTED = 8'h28;
  localparam logic [7:0] OFF_PEER_STATE = 8'h2C;
  localparam logic [7:0] OFF_PEER_LOG = 8'h30;
  localparam logic [7:0] OFF_STACK_CTRL = 8'h40;

  // Flag bit positions
  localparam int unsigned BIT_STARTED = 0;
  localparam int unsigned BIT_CONFIGURED = 1;
  localparam int unsigned BIT_PERMISSION = 2;
  localparam int unsigned BIT_PROTECT = 3;
  localparam int unsigned BIT_PENDING = 4;
  localparam int unsigned BIT_RESTART = 5;
  localparam int unsigned BIT_PERMIT = 6;
  localparam int unsigned FLAG_W = 7;

  // Stack control register bit positions
  localparam int unsigned CTL_REINIT = 0;
  localparam int unsigned CTL_RESTART = 1;

  localparam logic [15:0] STRUCT_VERSION = 16'h0001;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    NET_UNKNOWN = 3'h0,
    NET_OFFLINE = 3'h1,
    NET_STOP = 3'h2,
    NET_IDLE = 3'h3,
    NET_OPERATE = 3'h4
  } net_state_t;

  typedef enum logic [1:0] {
    PEER_UNDEFINED = 2'h0,
    PEER_OK = 2'h1,
    PEER_FAILED = 2'h2
  } peer_state_t;

  // Status from the protocol stack, sampled each clock
  typedef struct packed {
    logic started;
    logic configured;
    logic permission;
    logic protect;
    logic pending;
    logic restart_req;
    logic permit;
    net_state_t net_state;
    logic [31:0] error_code;
    logic error_event;
    logic acyclic_only;
    logic valid_config;
    logic [31:0] active_slaves;
    logic [31:0] configured_slaves;
    logic [31:0] faulted_slaves;
    logic [15:0] timeout_ms;
  } stack_status_t;

endpackage

/* src/remote_network_status_block.sv */
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps

module remote_network_status_block #(
  parameter bit MASTER_VARIANT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [status_pkg::ADDR_W-1:0] paddr,
  input wire logic [status_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [status_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire status_pkg::stack_status_t stack_status,
  output logic reinit_pulse,
  output logic restart_pulse,
  output logic network_enable
);
  import status_pkg::*;

  logic [FLAG_W-1:0] flags;
  net_state_t net_state;
  logic [31:0] error_code;
  logic [31:0] error_counter;
  logic [15:0] timeout_ms;
  logic [31:0] active_count;
  logic [31:0] configured_count;
  logic [31:0] faulted_count;
  peer_state_t peer_state;
  logic [31:0] next_rdata;
  logic next_slverr;
  logic access;
  logic wr_ctrl;

  function automatic logic master_only(input logic [7:0] a);
    master_only = (a == OFF_ACTIVE) || (a == OFF_CONFIGURED) || (a == OFF_FAULTED) ||
                  (a == OFF_PEER_STATE) || (a == OFF_PEER_LOG);
  endfunction

  assign access = psel && penable;
  assign wr_ctrl = access && pwrite && (paddr == OFF_STACK_CTRL) && pstrb[0];

  // Status flags mirrored from the stack, except started, which is set by started or configured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags[BIT_STARTED] <= stack_status.started || stack_status.configured;
      flags[BIT_CONFIGURED] <= stack_status.configured;
      flags[BIT_PERMISSION] <= stack_status.permission;
      flags[BIT_PROTECT] <= stack_status.protect;
      flags[BIT_PENDING] <= stack_status.pending;
      flags[BIT_RESTART] <= stack_status.restart_req;
      flags[BIT_PERMIT] <= stack_status.permit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_state <= NET_UNKNOWN;
      error_code <= RESET_ZERO;
      timeout_ms <= 16'h0000;
    end else begin
      net_state <= stack_status.net_state;
      error_code <= stack_status.error_code;
      timeout_ms <= stack_status.timeout_ms;
    end
  end

  // Counter clears on a permitted reinit, the event still counts that cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_counter <= RESET_ZERO;
    end else if (wr_ctrl && pwdata[CTL_REINIT] && !flags[BIT_PROTECT]) begin
      error_counter <= stack_status.error_event ? 32'h0000_0001 : RESET_ZERO;
    end else if (stack_status.error_event) begin
      error_counter <= error_counter + 32'h0000_0001;
    end
  end

  // Master-only fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_count <= RESET_ZERO;
      configured_count <= RESET_ZERO;
      faulted_count <= RESET_ZERO;
      peer_state <= PEER_UNDEFINED;
    end else if (MASTER_VARIANT) begin
      active_count <= stack_status.active_slaves;
      configured_count <= stack_status.configured_slaves;
      faulted_count <= stack_status.faulted_slaves;
      if (stack_status.acyclic_only) begin
        peer_state <= stack_status.valid_config ? PEER_OK : PEER_UNDEFINED;
      end else if (!stack_status.valid_config) begin
        peer_state <= PEER_UNDEFINED;
      end else if ((stack_status.active_slaves < stack_status.configured_slaves) ||
                   (stack_status.faulted_slaves != RESET_ZERO)) begin
        peer_state <= PEER_FAILED;
      end else begin
        peer_state <= PEER_OK;
      end
    end
  end

  // Command pulses; refused commands leave no trace
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reinit_pulse <= 1'b0;
      restart_pulse <= 1'b0;
      network_enable <= 1'b0;
    end else begin
      reinit_pulse <= wr_ctrl && pwdata[CTL_REINIT] && !flags[BIT_PROTECT];
      restart_pulse <= wr_ctrl && pwdata[CTL_RESTART] && flags[BIT_PERMIT] && flags[BIT_RESTART];
      network_enable <= flags[BIT_PERMISSION];
    end
  end

  // Read mux
  always_comb begin
    next_rdata = RESET_ZERO;
    next_slverr = 1'b0;
    unique case (paddr)
      OFF_STATE_FLAGS: next_rdata = {25'h0, flags};
      OFF_NET_STATE: next_rdata = {29'h0, net_state};
      OFF_ERR_CODE: next_rdata = error_code;
      OFF_ERR_COUNT: next_rdata = error_counter;
      OFF_ERR_LOG, OFF_HOST_SUP: next_rdata = RESET_ZERO;
      OFF_VERSION: next_rdata = {16'h0000, STRUCT_VERSION};
      OFF_TIMEOUT: next_rdata = {16'h0000, timeout_ms};
      OFF_ACTIVE: next_rdata = active_count;
      OFF_CONFIGURED: next_rdata = configured_count;
      OFF_FAULTED: next_rdata = faulted_count;
      OFF_PEER_STATE: next_rdata = {30'h0, peer_state};
      OFF_PEER_LOG: next_rdata = RESET_ZERO;
      OFF_STACK_CTRL: next_rdata = RESET_ZERO;
      default: next_slverr = 1'b1;
    endcase
    if (!MASTER_VARIANT && master_only(paddr)) begin
      next_rdata = RESET_ZERO;
      next_slverr = 1'b1;
    end
    if (pwrite && paddr != OFF_STACK_CTRL) begin
      next_slverr = 1'b1;
    end
  end

  // APB: no wait states, answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= RESET_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? RESET_ZERO : next_rdata;
        pslverr <= next_slverr;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  chk_flags_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && paddr == OFF_STATE_FLAGS) |-> prdata[31:FLAG_W] == '0)
    else $error("flag word upper bits nonzero");

  chk_started_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    stack_status.configured |=> flags[BIT_STARTED] && flags[BIT_CONFIGURED])
    else $error("configured without started");

  chk_started_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    stack_status.started |=> flags[BIT_STARTED])
    else $error("started flag missing");

  chk_started_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!stack_status.started && !stack_status.configured) |=> !flags[BIT_STARTED])
    else $error("started flag set without stack start");

  chk_configured_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    !stack_status.configured |=> !flags[BIT_CONFIGURED])
    else $error("configured flag set without configuration");

  chk_permission_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> flags[BIT_PERMISSION] == $past(stack_status.permission))
    else $error("permission flag not following stack");

  chk_permission_out: assert property (
    @(posedge pclk) disable iff (!presetn)
    stack_status.permission ##1 1'b1 |=> network_enable)
    else $error("network enable not following permission");

  chk_protect_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> flags[BIT_PROTECT] == $past(stack_status.protect))
    else $error("protect flag not following stack");

  chk_reinit_refused: assert property (
    @(posedge pclk) disable iff (!presetn)
    flags[BIT_PROTECT] |=> !reinit_pulse)
    else $error("reinit while protected");

  chk_reinit_accept: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[CTL_REINIT] && !flags[BIT_PROTECT]) |=> reinit_pulse)
    else $error("permitted reinit not issued");

  chk_pending_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    stack_status.pending |=> flags[BIT_PENDING])
    else $error("pending flag missing");

  chk_restart_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    stack_status.restart_req |=> flags[BIT_RESTART])
    else $error("restart flag missing");

  chk_permit_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> flags[BIT_PERMIT] == $past(stack_status.permit))
    else $error("restart permit flag not following stack");

  chk_restart_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    restart_pulse |-> $past(flags[BIT_PERMIT]))
    else $error("restart without permit");

  chk_restart_needs_req: assert property (
    @(posedge pclk) disable iff (!presetn)
    restart_pulse |-> $past(flags[BIT_RESTART]))
    else $error("restart without restart request");

  chk_restart_accept: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[CTL_RESTART] && flags[BIT_PERMIT] && flags[BIT_RESTART]) |=> restart_pulse)
    else $error("permitted restart not issued");

  chk_net_state_copy: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> net_state == $past(stack_status.net_state))
    else $error("network state not following stack");

  chk_net_state_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == OFF_NET_STATE) |=> prdata == {29'h0, $past(net_state)})
    else $error("network state read wrong");

  chk_err_code: assert property (
    @(posedge pclk) disable iff (!presetn)
    stack_status.error_code == '0 |=> error_code == '0)
    else $error("error code not cleared");

  chk_err_code_copy: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> error_code == $past(stack_status.error_code))
    else $error("error code not following stack");

  chk_err_count_inc: assert property (
    @(posedge pclk) disable iff (!presetn)
    (stack_status.error_event && !wr_ctrl && error_counter != 32'hFFFF_FFFF)
      |=> error_counter == $past(error_counter) + 32'h0000_0001)
    else $error("error counter did not advance");

  chk_err_count_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!stack_status.error_event && !wr_ctrl) |=> $stable(error_counter))
    else $error("error counter moved without an error");

  chk_err_count_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[CTL_REINIT] && !flags[BIT_PROTECT] && !stack_status.error_event) |=> error_counter == '0)
    else $error("error counter not cleared by reinit");

  chk_protect_keeps_count: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[CTL_REINIT] && flags[BIT_PROTECT] && !stack_status.error_event) |=> $stable(error_counter))
    else $error("refused reinit changed error counter");

  chk_active_copy: assert property (
    @(posedge pclk) disable iff (!presetn)
    (MASTER_VARIANT == 1'b1) |=> active_count == $past(stack_status.active_slaves))
    else $error("active slave count not following stack");

  chk_configured_copy: assert property (
    @(posedge pclk) disable iff (!presetn)
    (MASTER_VARIANT == 1'b1) |=> configured_count == $past(stack_status.configured_slaves))
    else $error("configured slave count not following stack");

  chk_faulted_copy: assert property (
    @(posedge pclk) disable iff (!presetn)
    (MASTER_VARIANT == 1'b1) |=> faulted_count == $past(stack_status.faulted_slaves))
    else $error("faulted slave count not following stack");

  chk_peer_failed: assert property (
    @(posedge pclk) disable iff (!presetn)
    (MASTER_VARIANT && !stack_status.acyclic_only && stack_status.valid_config &&
     stack_status.faulted_slaves != '0) |=> peer_state == PEER_FAILED)
    else $error("peer state not failed");

  chk_peer_missing: assert property (
    @(posedge pclk) disable iff (!presetn)
    (MASTER_VARIANT && !stack_status.acyclic_only && stack_status.valid_config &&
     stack_status.active_slaves < stack_status.configured_slaves) |=> peer_state == PEER_FAILED)
    else $error("missing slave not reported as failed");

  chk_peer_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    (MASTER_VARIANT && !stack_status.acyclic_only && stack_status.valid_config &&
     stack_status.active_slaves >= stack_status.configured_slaves &&
     stack_status.faulted_slaves == '0) |=> peer_state == PEER_OK)
    else $error("healthy slaves not reported as ok");

  chk_peer_acyclic: assert property (
    @(posedge pclk) disable iff (!presetn)
    (MASTER_VARIANT && stack_status.acyclic_only && stack_status.valid_config) |=> peer_state == PEER_OK)
    else $error("acyclic peer state not ok");

  chk_version_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == OFF_VERSION) |=> prdata == 32'h0000_0001)
    else $error("version not one");

  chk_timeout_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == OFF_TIMEOUT) |=> prdata == {16'h0000, $past(timeout_ms)})
    else $error("timeout read wrong");

  chk_unsupported_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && (paddr == OFF_ERR_LOG || paddr == OFF_HOST_SUP)) |=> prdata == '0)
    else $error("unsupported field nonzero");

  chk_peer_log_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == OFF_PEER_LOG) |=> prdata == '0)
    else $error("peer error log field nonzero");

  chk_slave_fields_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    !MASTER_VARIANT |-> (active_count == '0 && configured_count == '0 && faulted_count == '0 && peer_state == PEER_UNDEFINED))
    else $error("master-only field live in slave variant");

  chk_slave_read_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!MASTER_VARIANT && psel && !penable && master_only(paddr)) |=> (pslverr && prdata == '0))
    else $error("master-only field readable in slave variant");

  chk_ready_after_setup: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no ready after setup cycle");

endmodule

/* bench/status_host_model.sv */
`timescale 1ns/10ps
module status_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [status_pkg::ADDR_W-1:0] paddr,
  output logic [status_pkg::DATA_W-1:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [status_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import status_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
  end
  // One transfer; hung reports that no answer came within the bound
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err, output logic hung);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    err = pslverr;
    hung = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* bench/tb_remote_network_status_block.sv */
`timescale 1ns/10ps
module tb_remote_network_status_block;
  import status_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, psel_m, psel_s, penable, pwrite, use_s;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, prdata_m, prdata_s;
  logic [3:0] pstrb;
  logic pready, pready_m, pready_s, pslverr, pslverr_m, pslverr_s;
  logic reinit_pulse, restart_pulse, network_enable;
  stack_status_t stat;
  int error_cnt = 0, num_checks = 0, n_reinit = 0, n_restart = 0;
  always #20 pclk = ~pclk;
  assign psel_m = psel & ~use_s;
  assign psel_s = psel & use_s;
  assign prdata = use_s ? prdata_s : prdata_m;
  assign pready = use_s ? pready_s : pready_m;
  assign pslverr = use_s ? pslverr_s : pslverr_m;
  always @(posedge pclk) begin
    if (reinit_pulse === 1'b1) n_reinit++;
    if (restart_pulse === 1'b1) n_restart++;
  end
  status_host_model status_host_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  remote_network_status_block remote_network_status_block_i (.pclk(pclk), .presetn(presetn), .psel(psel_m),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_m),
    .pready(pready_m), .pslverr(pslverr_m), .stack_status(stat), .reinit_pulse(reinit_pulse),
    .restart_pulse(restart_pulse), .network_enable(network_enable));
  remote_network_status_block #(.MASTER_VARIANT(1'b0)) remote_network_status_block_slave_i (.pclk(pclk),
    .presetn(presetn), .psel(psel_s), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata_s), .pready(pready_s), .pslverr(pslverr_s), .stack_status(stat),
    .reinit_pulse(), .restart_pulse(), .network_enable());
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic eexp,
      output logic [31:0] q);
    logic e, h;
    status_host_model_i.xfer(wr, a, d, q, e, h);
    if (h) begin
      error_cnt++;
      $display("MISMATCH pready expected 1 seen 0");
      report_and_stop();
    end
    chk("pslverr", {31'h0, eexp}, {31'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, eexp, q);
    chk($sformatf("prdata at %h", a), exp, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eexp);
    logic [31:0] q;
    acc(1'b1, a, d, eexp, q);
  endtask
  task automatic put(input stack_status_t s);
    @(posedge pclk);
    stat <= s;
  endtask
  task automatic t_reset();
    for (int a = 0; a <= 'h30; a += 4) rd(8'(a), (a == 'h18) ? 32'h1 : 32'h0, 1'b0);
    rd(OFF_STACK_CTRL, 32'h0, 1'b0);
    $display("reset values done");
  endtask
  task automatic t_flags();
    stack_status_t s;
    for (int i = 0; i < 8; i++) begin
      s = stat;
      {s.started, s.configured, s.permission, s.protect, s.pending, s.restart_req, s.permit} = (i == 7) ? 7'h7F : 7'h40 >> i;
      put(s);
      rd(OFF_STATE_FLAGS, (i == 7) ? 32'h7F : (i == 1) ? 32'h3 : 32'h1 << i, 1'b0);
      chk("network_enable", {31'h0, i == 2 || i == 7}, {31'h0, network_enable});
    end
    put('0);
    $display("flag word done");
  endtask
  task automatic t_values();
    stack_status_t s;
    for (int k = 0; k < 5; k++) begin
      s = '0;
      s.net_state = net_state_t'(k);
      s.error_code = (k == 0) ? 32'h0 : 32'hA5C3_0000 + k;
      s.timeout_ms = 16'hFFFF - 16'(k);
      s.active_slaves = k;
      s.configured_slaves = k + 7;
      s.faulted_slaves = 32'h8000_0000 >> k;
      put(s);
      rd(OFF_NET_STATE, k, 1'b0);
      rd(OFF_ERR_CODE, s.error_code, 1'b0);
      rd(OFF_TIMEOUT, {16'h0, s.timeout_ms}, 1'b0);
      rd(OFF_ACTIVE, k, 1'b0);
      rd(OFF_CONFIGURED, k + 7, 1'b0);
      rd(OFF_FAULTED, s.faulted_slaves, 1'b0);
      rd(OFF_ERR_LOG, 32'h0, 1'b0);
      rd(OFF_HOST_SUP, 32'h0, 1'b0);
      rd(OFF_PEER_LOG, 32'h0, 1'b0);
    end
    $display("value fields done");
  endtask
  task automatic t_peer();
    stack_status_t s;
    for (int k = 0; k < 5; k++) begin
      s = '0;
      s.valid_config = (k != 0);
      s.acyclic_only = (k == 4);
      s.active_slaves = (k == 2 || k == 4) ? 32'h0 : 32'h3;
      s.configured_slaves = 32'h3;
      s.faulted_slaves = (k == 3) ? 32'h1 : 32'h0;
      put(s);
      rd(OFF_PEER_STATE, (k == 0) ? 32'h0 : (k == 2 || k == 3) ? 32'h2 : 32'h1, 1'b0);
    end
    $display("peer state done");
  endtask
  task automatic t_count();
    stack_status_t s;
    s = '0;
    repeat (3) begin
      s.error_event = 1'b1;
      put(s);
      s.error_event = 1'b0;
      put(s);
    end
    rd(OFF_ERR_COUNT, 32'h3, 1'b0);
    s.protect = 1'b1;
    put(s);
    wr(OFF_STACK_CTRL, 32'h1, 1'b0);
    rd(OFF_ERR_COUNT, 32'h3, 1'b0);
    chk("reinit pulses", 32'h0, n_reinit);
    put('0);
    wr(OFF_STACK_CTRL, 32'h1, 1'b0);
    rd(OFF_ERR_COUNT, 32'h0, 1'b0);
    chk("reinit pulses", 32'h1, n_reinit);
    $display("error counter done");
  endtask
  task automatic t_restart();
    stack_status_t s;
    for (int k = 0; k < 3; k++) begin
      s = '0;
      s.restart_req = (k != 1);
      s.permit = (k != 0);
      put(s);
      wr(OFF_STACK_CTRL, 32'h2, 1'b0);
      rd(OFF_STACK_CTRL, 32'h0, 1'b0);
      chk("restart pulses", (k == 2) ? 32'h1 : 32'h0, n_restart);
    end
    $display("restart done");
  endtask
  task automatic t_refuse();
    wr(OFF_ERR_CODE, 32'hFFFF_FFFF, 1'b1);
    rd(OFF_ERR_CODE, 32'h0, 1'b0);
    rd(8'h34, 32'h0, 1'b1);
    rd(8'hFC, 32'h0, 1'b1);
    $display("refusals done");
  endtask
  task automatic t_slave();
    @(posedge pclk);
    use_s <= 1'b1;
    for (int i = 0; i < 5; i++) rd(OFF_ACTIVE + 8'(4 * i), 32'h0, 1'b1);
    rd(OFF_VERSION, 32'h1, 1'b0);
    rd(OFF_ERR_COUNT, 32'h3, 1'b0);
    $display("slave variant done");
  endtask
  task automatic t_rst_mid();
    put('0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_ERR_COUNT, 32'h0, 1'b0);
    rd(OFF_STATE_FLAGS, 32'h0, 1'b0);
    $display("mid-run reset done");
  endtask
  initial begin
    stat = '0;
    use_s = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_flags();
    t_values();
    t_peer();
    t_count();
    t_restart();
    t_refuse();
    t_slave();
    t_rst_mid();
    report_and_stop();
  end
endmodule
